// ==== src/qpk_ports.sv ====
// quad 8-bit bidirectional ports with port a edge-detecting keyboard interrupt, apb slave
`timescale 1ns/1ps
module qpk_ports
   import qpk_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_a_pins_in,
   input  wire logic [7:0]  port_b_pins_in,
   input  wire logic [7:0]  port_c_pins_in,
   input  wire logic [7:0]  port_d_pins_in,
   output qpk_pin_drive_s   port_a_drive,
   output qpk_pin_drive_s   port_b_drive,
   output qpk_pin_drive_s   port_c_drive,
   output qpk_pin_drive_s   port_d_drive,
   output logic [7:0]       port_a_pullup_en,
   output logic             key_irq
);
   logic [7:0] data_latch [4];
   logic [7:0] direction [4];
   logic [7:0] sync1 [4];
   logic [7:0] sync2 [4];
   logic [7:0] prev_a;
   logic [7:0] key_edge_status;
   logic       key_summary_flag;
   logic       key_irq_enable;
   logic       status_read_select;
   logic       cpu_mask;
   logic [5:0] edge_polarity_select;
   logic       acc_setup;
   logic       wr_acc;
   logic       rd_acc;
   logic [7:0] rise_mask;
   logic [7:0] hit;
   logic [7:0] status_w1c;
   logic       clear_all;
   logic       addr_ok;
   logic [7:0] next_rdata;
   logic [1:0] reg_idx;
   logic       data_sel;
   logic       dir_sel;

   // a single wait-free access phase; setup is refused nothing
   assign acc_setup = psel & ~penable;
   assign wr_acc    = psel & penable & pwrite;
   assign rd_acc    = psel & penable & ~pwrite;

   function automatic logic is_data(input logic [7:0] a);
      return (a[7:4] == 4'h0) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic is_dir(input logic [7:0] a);
      return (a[7:4] == 4'h1) && (a[1:0] == 2'b00);
   endfunction

   // one decode serves both the write and the read path
   assign reg_idx  = paddr[3:2];
   assign data_sel = is_data(paddr);
   assign dir_sel  = is_dir(paddr);

   // ---------------- synchronisers ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // idle high like the pull-ups, so release shows no false falling edge
         for (int i = 0; i < 4; i++) begin
            sync1[i] <= 8'hFF;
            sync2[i] <= 8'hFF;
         end
         prev_a <= 8'hFF;
      end else begin
         sync1[0] <= port_a_pins_in;
         sync1[1] <= port_b_pins_in;
         sync1[2] <= port_c_pins_in;
         sync1[3] <= port_d_pins_in;
         for (int i = 0; i < 4; i++) begin
            sync2[i] <= sync1[i];
         end
         prev_a <= sync2[0];
      end
   end

   // ---------------- edge detection ----------------
   // lines 6 and 7 stay falling-only whatever is written
   assign rise_mask = {2'b00, edge_polarity_select} & ~FALLING_ONLY_MASK;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (rise_mask[i]) begin
            hit[i] = ~prev_a[i] & sync2[0][i];
         end else begin
            hit[i] = prev_a[i] & ~sync2[0][i];
         end
      end
      hit = hit & ~direction[0];
   end

   // ---------------- data latches ----------------
   // no reset branch: latch contents survive reset
   always_ff @(posedge pclk) begin
      if (wr_acc && data_sel) begin
         if (!(reg_idx == 2'd0 && status_read_select)) begin
            data_latch[reg_idx] <= pwdata[7:0];
         end
      end
   end

   // ---------------- direction registers ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            direction[i] <= RST_DIRECTION;
         end
      end else if (wr_acc && dir_sel) begin
         direction[reg_idx] <= pwdata[7:0];
      end
   end

   // ---------------- control and option registers ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_irq_enable       <= RST_KCR[KCR_ENABLE_BIT];
         status_read_select   <= RST_OPTION[OPT_MUX_BIT];
         cpu_mask             <= RST_OPTION[OPT_CPUMASK_BIT];
         edge_polarity_select <= RST_EDGE;
      end else if (wr_acc) begin
         if (paddr == OFF_KEYBOARD_CONTROL) begin
            key_irq_enable <= pwdata[KCR_ENABLE_BIT];
         end else if (paddr == OFF_KEY_OPTION) begin
            status_read_select <= pwdata[OPT_MUX_BIT];
            cpu_mask           <= pwdata[OPT_CPUMASK_BIT];
         end else if (paddr == OFF_EDGE_SELECT) begin
            edge_polarity_select <= pwdata[EDGE_SEL_BITS-1:0];
         end
      end
   end

   // ---------------- status flags ----------------
   assign clear_all  = wr_acc && (paddr == OFF_KEY_OPTION) && pwdata[OPT_CLR_BIT];
   assign status_w1c = (wr_acc && (paddr == OFF_PORT_A_DATA) && status_read_select) ? pwdata[7:0] : 8'h00;

   // a new edge wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_edge_status <= RST_STATUS;
      end else if (clear_all) begin
         key_edge_status <= hit;
      end else begin
         key_edge_status <= (key_edge_status & ~status_w1c) | hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_summary_flag <= RST_KCR[KCR_FLAG_BIT];
      end else if (key_irq_enable && (|hit)) begin
         key_summary_flag <= 1'b1;
      end else if (acc_setup && (paddr == OFF_PORT_A_DATA)) begin
         key_summary_flag <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_irq <= 1'b0;
      end else begin
         key_irq <= key_irq_enable & key_summary_flag & ~cpu_mask;
      end
   end

   // ---------------- pins ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_drive     <= '0;
         port_b_drive     <= '0;
         port_c_drive     <= '0;
         port_d_drive     <= '0;
         port_a_pullup_en <= 8'hFF;
      end else begin
         port_a_drive     <= '{out: data_latch[0], oe: direction[0]};
         port_b_drive     <= '{out: data_latch[1], oe: direction[1]};
         port_c_drive     <= '{out: data_latch[2], oe: direction[2]};
         port_d_drive     <= '{out: data_latch[3], oe: direction[3]};
         port_a_pullup_en <= ~rise_mask;
      end
   end

   // ---------------- apb read path ----------------
   always_comb begin
      next_rdata = 8'h00;
      addr_ok    = 1'b1;
      if (data_sel) begin
         if (reg_idx == 2'd0 && status_read_select) begin
            next_rdata = key_edge_status;
         end else begin
            next_rdata = (direction[reg_idx] & data_latch[reg_idx]) | (~direction[reg_idx] & sync2[reg_idx]);
         end
      end else if (dir_sel) begin
         next_rdata = direction[reg_idx];
      end else if (paddr == OFF_KEYBOARD_CONTROL) begin
         next_rdata = {key_summary_flag, key_irq_enable, 6'h00};
      end else if (paddr == OFF_KEY_OPTION) begin
         next_rdata = {5'h00, cpu_mask, 1'b0, status_read_select};
      end else if (paddr == OFF_EDGE_SELECT) begin
         next_rdata = {2'b00, edge_polarity_select};
      end else begin
         addr_ok = 1'b0;
      end
   end

   // answer registered in setup, so access phase completes with no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc_setup;
         pslverr <= acc_setup & ~addr_ok;
         if (acc_setup && !pwrite) begin
            prdata <= {24'h00_0000, next_rdata};
         end
      end
   end

   // ---------------- assertions ----------------
   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn)
      key_irq |-> $past(key_irq_enable) && $past(key_summary_flag) && !$past(cpu_mask);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable, flag and unmasked cpu");

   property p_no_flag_disabled;
      @(posedge pclk) disable iff (!presetn)
      (!key_irq_enable && !key_summary_flag) |=> !key_summary_flag;
   endproperty
   a_no_flag_disabled: assert property (p_no_flag_disabled) else $error("flag set while disabled");

   property p_falling_hi;
      @(posedge pclk) disable iff (!presetn)
      (!direction[0][7] && prev_a[7] && !sync2[0][7]) |=> key_edge_status[7];
   endproperty
   a_falling_hi: assert property (p_falling_hi) else $error("line 7 fall not flagged");

   property p_pullup_off;
      @(posedge pclk) disable iff (!presetn)
      edge_polarity_select[0] |=> !port_a_pullup_en[0];
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pullup on for rising line");

   property p_summary_or;
      @(posedge pclk) disable iff (!presetn)
      (key_irq_enable && |hit) |=> key_summary_flag;
   endproperty
   a_summary_or: assert property (p_summary_or) else $error("summary not set on edge");

   property p_port_a_data_clears;
      @(posedge pclk) disable iff (!presetn)
      (acc_setup && paddr == OFF_PORT_A_DATA && !(key_irq_enable && |hit)) |=> !key_summary_flag;
   endproperty
   a_port_a_data_clears: assert property (p_port_a_data_clears) else $error("port a access left flag");

   property p_clear_all;
      @(posedge pclk) disable iff (!presetn)
      (clear_all && hit == 8'h00) |=> key_edge_status == 8'h00;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("clear-all ignored");

   property p_output_no_key;
      @(posedge pclk) disable iff (!presetn)
      direction[0][2] |-> !hit[2];
   endproperty
   a_output_no_key: assert property (p_output_no_key) else $error("output pin fed keyboard");

   property p_ready_once;
      @(posedge pclk) disable iff (!presetn)
      acc_setup |=> pready ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready not single cycle");

   property p_rise_line;
      @(posedge pclk) disable iff (!presetn)
      (!direction[0][0] && edge_polarity_select[0] && !prev_a[0] && sync2[0][0]) |=> key_edge_status[0];
   endproperty
   a_rise_line: assert property (p_rise_line) else $error("line 0 rise not flagged");

   property p_status_set;
      @(posedge pclk) disable iff (!presetn)
      (|hit) |=> ((key_edge_status & $past(hit)) == $past(hit));
   endproperty
   a_status_set: assert property (p_status_set) else $error("edge left its status flag clear");

   property p_mux_read;
      @(posedge pclk) disable iff (!presetn)
      (acc_setup && !pwrite && paddr == OFF_PORT_A_DATA && status_read_select)
         |=> prdata[7:0] == $past(key_edge_status);
   endproperty
   a_mux_read: assert property (p_mux_read) else $error("status not read at address zero");

   property p_kcr_read;
      @(posedge pclk) disable iff (!presetn)
      (acc_setup && !pwrite && paddr == OFF_KEYBOARD_CONTROL)
         |=> prdata == {24'h00_0000, $past(key_summary_flag), $past(key_irq_enable), 6'h00};
   endproperty
   a_kcr_read: assert property (p_kcr_read) else $error("control register read wrong");

   property p_latch_drive;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFF_PORT_B_DATA)
         |=> (data_latch[1] == $past(pwdata[7:0])) ##1 (port_b_drive.out == $past(pwdata[7:0], 2));
   endproperty
   a_latch_drive: assert property (p_latch_drive) else $error("port b latch or drive not updated");

   property p_read_mix;
      @(posedge pclk) disable iff (!presetn)
      (acc_setup && !pwrite && paddr == OFF_PORT_C_DATA)
         |=> prdata[7:0] == $past((direction[2] & data_latch[2]) | (~direction[2] & sync2[2]));
   endproperty
   a_read_mix: assert property (p_read_mix) else $error("port c read mixes pin and latch wrongly");

   property p_dir_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFF_PORT_A_DIRECTION) |=> direction[0] == $past(pwdata[7:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("port a direction not written");

   property p_dir_reset;
      @(posedge pclk)
      $rose(presetn) |-> (direction[0] | direction[1] | direction[2] | direction[3]) == RST_DIRECTION;
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");

   property p_w1c_one;
      @(posedge pclk) disable iff (!presetn)
      (status_w1c != 8'h00 && hit == 8'h00 && !clear_all)
         |=> key_edge_status == ($past(key_edge_status) & ~$past(status_w1c));
   endproperty
   a_w1c_one: assert property (p_w1c_one) else $error("write-one clear touched other flags");

   property p_irq_disabled;
      @(posedge pclk) disable iff (!presetn)
      !key_irq_enable |=> !key_irq;
   endproperty
   a_irq_disabled: assert property (p_irq_disabled) else $error("irq while keyboard disabled");

   property p_pullup_fixed;
      @(posedge pclk) disable iff (!presetn)
      port_a_pullup_en[7:6] == 2'b11;
   endproperty
   a_pullup_fixed: assert property (p_pullup_fixed) else $error("pullup off on falling-only line");

   property p_dir_read;
      @(posedge pclk) disable iff (!presetn)
      (acc_setup && !pwrite && paddr == OFF_PORT_D_DIRECTION) |=> prdata[7:0] == $past(direction[3]);
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("port d direction read wrong");

   c_irq:   cover property (@(posedge pclk) disable iff (!presetn) $rose(key_irq));
   c_rise:  cover property (@(posedge pclk) disable iff (!presetn) hit[0] && rise_mask[0]);
   c_mux:   cover property (@(posedge pclk) disable iff (!presetn) rd_acc && status_read_select && paddr == 8'h00);
   c_w1c:   cover property (@(posedge pclk) disable iff (!presetn) |status_w1c);
endmodule

// ==== src/qpk_pkg.sv ====
// package: register map, field positions and carrier types for the quad port block
package qpk_pkg;
   localparam logic [7:0] OFF_PORT_A_DATA      = 8'h00;
   localparam logic [7:0] OFF_PORT_B_DATA      = 8'h04;
   localparam logic [7:0] OFF_PORT_C_DATA      = 8'h08;
   localparam logic [7:0] OFF_PORT_D_DATA      = 8'h0C;
   localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h10;
   localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h14;
   localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h18;
   localparam logic [7:0] OFF_PORT_D_DIRECTION = 8'h1C;
   localparam logic [7:0] OFF_KEYBOARD_CONTROL = 8'h40;
   localparam logic [7:0] OFF_KEY_OPTION       = 8'h44;
   localparam logic [7:0] OFF_EDGE_SELECT      = 8'h48;
   localparam int KCR_FLAG_BIT   = 7;
   localparam int KCR_ENABLE_BIT = 6;
   localparam int OPT_MUX_BIT    = 0;
   localparam int OPT_CLR_BIT    = 1;
   localparam int OPT_CPUMASK_BIT = 2;
   localparam int EDGE_SEL_BITS  = 6;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_KCR       = 8'h00;
   localparam logic [7:0] RST_STATUS    = 8'h00;
   localparam logic [5:0] RST_EDGE      = 6'h00;
   localparam logic [2:0] RST_OPTION    = 3'h0;
   localparam logic [7:0] FALLING_ONLY_MASK = 8'hC0;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } qpk_pin_drive_s;
endpackage

// ==== tb/qpk_pin_model.sv ====
// behavioural pin model: keypad switches and pull resistors on one 8-bit port
`timescale 1ns/1ps
module qpk_pin_model
   import qpk_pkg::*;
(
   input  wire logic       pclk,
   input  qpk_pin_drive_s  drv,
   input  wire logic [7:0] sw_val,
   input  wire logic [7:0] sw_en,
   input  wire logic [7:0] pull,
   output logic      [7:0] pins
);
   logic [7:0] float_pat = 8'h55;
   // a floating line wanders each cycle so a stale level never passes for data
   always @(posedge pclk) begin
      float_pat <= ~float_pat;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pins[i] = drv.oe[i] ? drv.out[i] : sw_en[i] ? sw_val[i] : pull[i] ? 1'b1 : float_pat[i];
      end
   end
endmodule

// ==== tb/quad_port_with_key_wakeup_tb.sv ====
// self-checking bench for the quad port block with keyboard edge flags
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module quad_port_with_key_wakeup_tb
   import qpk_pkg::*;
;
   typedef struct packed {
      logic       w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
      logic       x;
   } qpk_row_s;
   localparam qpk_row_s ROWS [14] = '{
      '{1, 8'h04, 8'hA5, 8'h00, 0}, '{1, 8'h14, 8'h0F, 8'h00, 0}, '{0, 8'h04, 8'h00, 8'hF5, 0},
      '{1, 8'h08, 8'h3C, 8'h00, 0}, '{1, 8'h18, 8'hFF, 8'h00, 0}, '{0, 8'h08, 8'h00, 8'h3C, 0},
      '{1, 8'h0C, 8'h81, 8'h00, 0}, '{1, 8'h1C, 8'hFF, 8'h00, 0}, '{0, 8'h1C, 8'h00, 8'hFF, 0},
      '{0, 8'h50, 8'h00, 8'h00, 1}, '{1, 8'h40, 8'h3F, 8'h00, 0}, '{0, 8'h40, 8'h00, 8'h00, 0},
      '{1, 8'h40, 8'h40, 8'h00, 0}, '{0, 8'h40, 8'h00, 8'h40, 0}};
   logic           pclk    = 1'b0;
   logic           presetn = 1'b0;
   logic           psel    = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite  = 1'b0;
   logic [7:0]     paddr   = 8'h00;
   logic [31:0]    pwdata  = 32'h0000_0000;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic           key_irq;
   logic [7:0]     pa, pb, pc, pd, pull_a;
   logic [7:0]     sw      = 8'hFF;
   logic [7:0]     sw_en_bcd = 8'h00;
   qpk_pin_drive_s da, db, dc, dd;
   logic [31:0]    rd;
   logic           er;
   int             err_total  = 0;
   int             num_checks = 0;
   int             cyc        = 0;

   always #12.5 pclk = ~pclk;

   qpk_ports qpk_ports_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_a_pins_in(pa), .port_b_pins_in(pb), .port_c_pins_in(pc),
      .port_d_pins_in(pd), .port_a_drive(da), .port_b_drive(db), .port_c_drive(dc),
      .port_d_drive(dd), .port_a_pullup_en(pull_a), .key_irq(key_irq));
   qpk_pin_model pins_a (.pclk(pclk), .drv(da), .sw_val(sw), .sw_en(8'hFF), .pull(pull_a), .pins(pa));
   qpk_pin_model pins_b (.pclk(pclk), .drv(db), .sw_val(sw), .sw_en(sw_en_bcd), .pull(8'hFF), .pins(pb));
   qpk_pin_model pins_c (.pclk(pclk), .drv(dc), .sw_val(sw), .sw_en(sw_en_bcd), .pull(8'hFF), .pins(pc));
   qpk_pin_model pins_d (.pclk(pclk), .drv(dd), .sw_val(sw), .sw_en(sw_en_bcd), .pull(8'hFF), .pins(pd));

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // read right after a rising edge, values are those that edge sampled (design updates land later)
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rx(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK("rdata", e, rd[7:0])
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end

   initial begin
      repeat (16) @(posedge pclk);
      `CHK("pullup", 8'hFF, pull_a)
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) rx(8'h10 + 8'(4 * i), 8'h00);
      // latch is loaded before direction turns the pin round
      foreach (ROWS[i]) begin
         apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         if (!ROWS[i].w) `CHK("rdata", ROWS[i].e, rd[7:0])
         `CHK("slverr", ROWS[i].x, er)
      end
      wt(2);
      `CHK("b_drive", 16'hA50F, db)
      `CHK("d_drive", 16'h81FF, dd)
      $display("test table done");
      @(posedge pclk);
      presetn <= 1'b0;
      wt(2);
      `CHK("c_oe", 8'h00, dc.oe)
      presetn <= 1'b1;
      rx(8'h40, 8'h00);
      apb(1'b1, 8'h18, 8'hFF);
      wt(2);
      `CHK("c_out", 8'h3C, dc.out)
      $display("test reset done");
      apb(1'b1, 8'h48, 8'h01);
      wt(2);
      `CHK("pullup", 8'hFE, pull_a)
      apb(1'b1, 8'h40, 8'h40);
      sw <= 8'hF7;
      wt(6);
      `CHK("irq", 1'b1, key_irq)
      rx(8'h40, 8'hC0);
      apb(1'b1, 8'h44, 8'h04);
      wt(2);
      `CHK("irq", 1'b0, key_irq)
      apb(1'b1, 8'h44, 8'h01);
      wt(2);
      `CHK("irq", 1'b1, key_irq)
      rx(8'h00, 8'h08);
      wt(2);
      `CHK("irq", 1'b0, key_irq)
      rx(8'h40, 8'h40);
      apb(1'b1, 8'h00, 8'h08);
      rx(8'h00, 8'h00);
      sw <= 8'hFE;
      wt(6);
      rx(8'h00, 8'h00);
      sw <= 8'hFF;
      wt(6);
      rx(8'h00, 8'h01);
      sw <= 8'h7F;
      wt(6);
      rx(8'h00, 8'h81);
      apb(1'b1, 8'h00, 8'h81);
      sw <= 8'hFF;
      wt(6);
      rx(8'h00, 8'h00);
      sw <= 8'hDF;
      wt(6);
      apb(1'b1, 8'h44, 8'h03);
      rx(8'h00, 8'h00);
      sw <= 8'hFF;
      $display("test edges done");
      apb(1'b1, 8'h40, 8'h00);
      sw <= 8'hFD;
      wt(6);
      `CHK("irq", 1'b0, key_irq)
      rx(8'h40, 8'h00);
      sw <= 8'hFF;
      apb(1'b1, 8'h44, 8'h02);
      apb(1'b1, 8'h00, 8'hFF);
      apb(1'b1, 8'h10, 8'h04);
      apb(1'b1, 8'h40, 8'h40);
      apb(1'b1, 8'h00, 8'hFB);
      wt(6);
      `CHK("a_drive", 16'hFB04, da)
      apb(1'b1, 8'h44, 8'h01);
      rx(8'h00, 8'h00);
      $display("test keyboard done");
      results();
   end
endmodule
